// File: logic/otw_params.svh
// Constants for the one-time-programmable wiper serial slave
`ifndef OTW_PARAMS_SVH
`define OTW_PARAMS_SVH

// ---------------------------------------------------------------
// Addressing
// ---------------------------------------------------------------
`define OTW_ADDR_PREFIX   6'h16   // Fixed upper address bits 010110
`define OTW_BITS_PER_BYTE 4'h8
`define OTW_LAST_TX_BIT   4'h7
`define OTW_PROG_BIT      7       // Instruction bit that requests fuse blowing

// ---------------------------------------------------------------
// Wiper and fuse validation codes
// ---------------------------------------------------------------
`define OTW_WIPER_W       6
`define OTW_MIDSCALE      6'h20
`define OTW_CHK_READY     2'h0
`define OTW_CHK_TESTFAIL  2'h1
`define OTW_CHK_FATAL     2'h2
`define OTW_CHK_DONE      2'h3

`endif

// File: logic/otw_pkg.sv
// Types shared by the wiper serial slave files
package otw_pkg;

    // ---------------------------------------------------------------
    // Bus sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_INSTR     = 4'h3,
        ST_INSTR_ACK = 4'h4,
        ST_DATA      = 4'h5,
        ST_DATA_ACK  = 4'h6,
        ST_RD        = 4'h7,
        ST_RD_ACK    = 4'h8,
        ST_SKIP      = 4'h9
    } otw_state_t;

endpackage : otw_pkg

// File: logic/otw_line_sync.sv
// Pin synchroniser and bus event detector for the wiper serial slave
`timescale 1ns/1ps
`default_nettype none

module otw_line_sync (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic [2:0] raw_in,       // {addr select, data, clock}
    output logic      [2:0] level_out,
    output logic            scl_rise_out,
    output logic            scl_fall_out,
    output logic            start_out,
    output logic            stop_out
);

    // ---------------------------------------------------------------
    // Two-stage synchronisers, then one history stage for edges
    // ---------------------------------------------------------------
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [1:0] prev_q;

    // Only sync_q looks at meta_q, so metastability stays contained
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            meta_q <= 3'h3;
            sync_q <= 3'h3;
            prev_q <= 2'h3;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
            prev_q <= sync_q[1:0];
        end
    end

    // Edges and bus conditions from the settled samples
    assign level_out    = sync_q;
    assign scl_rise_out = sync_q[0] && !prev_q[0];
    assign scl_fall_out = !sync_q[0] && prev_q[0];
    assign start_out    = sync_q[0] && prev_q[0] && prev_q[1] && !sync_q[1];
    assign stop_out     = sync_q[0] && prev_q[0] && !prev_q[1] && sync_q[1];

endmodule : otw_line_sync

`default_nettype wire

// File: logic/otw_slave.sv
// Two-wire serial slave with fuse-lockable six-bit wiper setting
`timescale 1ns/1ps
`default_nettype none
`include "otw_params.svh"

// What this block does
// - Data falling while clock high starts transfer
// - Address byte: 010110, select bit, direction
// - Address select bit must equal pin level
// - Matching address acknowledged on ninth pulse
// - Unmatched device never drives data line
// - Write: instruction byte, top bit programs
// - Write: data byte follows acknowledged instruction
// - Byte is eight bits MSB first, ack
// - Data changes only while clock low
// - Read: data byte right after address ack
// - Data rising while clock high ends transfer
// - Each further write byte reloads the wiper while not locked
// - After programming no further wiper updates
// - Reads may repeat, each returns valid data
// - Program bit set blows fuses at wiper
// - Read byte: two check bits, wiper code
// - Check codes: ready, test fail, fatal, done
// - Midscale at power-on unless fuses programmed
module otw_slave
    import otw_pkg::*;
(
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe_out,
    input  wire logic                     addr_select_pin_in,
    input  wire logic                     fuse_check_hi_in,
    input  wire logic                     fuse_check_lo_in,
    input  wire logic [`OTW_WIPER_W-1:0]  fuse_code_in,
    output logic      [`OTW_WIPER_W-1:0]  wiper_setting_out,
    output logic                          fuse_blow_out,
    output logic      [`OTW_WIPER_W-1:0]  fuse_code_out,
    output logic                          addressed_out
);

    // ---------------------------------------------------------------
    // Pin synchronisation and bus events
    // ---------------------------------------------------------------
    logic [2:0] lvl;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;

    otw_line_sync u_sync (
        .clk_in       (clk_in),
        .nrst_in      (nrst_in),
        .raw_in       ({addr_select_pin_in, sda_in, scl_in}),
        .level_out    (lvl),
        .scl_rise_out (scl_rise),
        .scl_fall_out (scl_fall),
        .start_out    (start_ev),
        .stop_out     (stop_ev)
    );

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    otw_state_t               state_q;
    otw_state_t               state_d;
    logic [3:0]               cnt_q;
    logic [3:0]               cnt_d;
    logic [7:0]               shreg_q;
    logic [7:0]               shreg_d;
    logic                     drive_q;
    logic                     drive_d;
    logic                     rw_q;
    logic                     rw_d;
    logic                     prog_q;
    logic                     prog_d;
    logic [`OTW_WIPER_W-1:0]  wiper_q;
    logic [`OTW_WIPER_W-1:0]  blow_code_q;
    logic                     blow_q;
    logic                     blown_q;
    logic                     boot_done_q;

    // ---------------------------------------------------------------
    // Decoding
    // ---------------------------------------------------------------
    logic                     scl_hi;
    logic                     sda_hi;
    logic                     sel_pin;
    logic                     byte_done;
    logic                     addr_ok;
    logic [1:0]               chk;
    logic                     locked;
    logic                     booting;
    logic                     upd_wiper;
    logic                     start_blow;
    logic [7:0]               rd_byte;
    logic [`OTW_WIPER_W-1:0]  rx_code;
    logic [7:0]               shift_in;

    assign scl_hi     = lvl[0];
    assign sda_hi     = lvl[1];
    assign sel_pin    = lvl[2];
    // Eighth bit already sampled and its clock pulse is over
    assign byte_done  = scl_fall && (cnt_q == `OTW_BITS_PER_BYTE);
    assign addr_ok    = (shreg_q[7:2] == `OTW_ADDR_PREFIX)
                        && (shreg_q[1] == sel_pin);
    assign chk        = {fuse_check_hi_in, fuse_check_lo_in};
    // Any fuse activity, ours or from an earlier life, freezes the wiper
    assign locked     = (chk != `OTW_CHK_READY) || blown_q;
    assign booting    = !boot_done_q;
    assign rx_code    = shreg_q[`OTW_WIPER_W-1:0];
    assign upd_wiper  = (state_q == ST_DATA) && byte_done && !locked && !booting;
    assign start_blow = upd_wiper && prog_q;
    assign rd_byte    = {chk, wiper_q};
    assign shift_in   = {shreg_q[6:0], sda_hi};

    // Received-bit counter increment, shared by every receive state
    function automatic logic [3:0] cnt_inc(input logic [3:0] c);
        cnt_inc = c + 4'h1;
    endfunction : cnt_inc

    // ---------------------------------------------------------------
    // Bus sequencer
    // ---------------------------------------------------------------
    // Drive changes only follow a detected clock fall, so the line
    // stays put while the clock is high; start and stop release it.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        shreg_d = shreg_q;
        drive_d = drive_q;
        rw_d    = rw_q;
        prog_d  = prog_q;
        if (start_ev) begin
            state_d = ST_ADDR;
            cnt_d   = 4'h0;
            drive_d = 1'b0;
        end else if (stop_ev) begin
            state_d = ST_IDLE;
            drive_d = 1'b0;
        end else begin
            case (state_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shreg_d = shift_in;
                        cnt_d   = cnt_inc(cnt_q);
                    end else if (byte_done) begin
                        if (addr_ok) begin
                            state_d = ST_ADDR_ACK;
                            drive_d = 1'b1;
                            rw_d    = shreg_q[0];
                        end else begin
                            state_d = ST_SKIP;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            state_d = ST_RD;
                            shreg_d = rd_byte;
                            drive_d = !rd_byte[7];
                        end else begin
                            state_d = ST_INSTR;
                            drive_d = 1'b0;
                        end
                    end
                end
                ST_INSTR: begin
                    if (scl_rise) begin
                        shreg_d = shift_in;
                        cnt_d   = cnt_inc(cnt_q);
                    end else if (byte_done) begin
                        state_d = ST_INSTR_ACK;
                        drive_d = 1'b1;
                        prog_d  = shreg_q[`OTW_PROG_BIT];
                    end
                end
                ST_INSTR_ACK: begin
                    if (scl_fall) begin
                        state_d = ST_DATA;
                        cnt_d   = 4'h0;
                        drive_d = 1'b0;
                    end
                end
                ST_DATA: begin
                    if (scl_rise) begin
                        shreg_d = shift_in;
                        cnt_d   = cnt_inc(cnt_q);
                    end else if (byte_done) begin
                        state_d = ST_DATA_ACK;
                        drive_d = 1'b1;
                    end
                end
                ST_DATA_ACK: begin
                    if (scl_fall) begin
                        cnt_d   = 4'h0;
                        drive_d = 1'b0;
                        // Same instruction keeps applying; once fused, one pass only
                        state_d = locked ? ST_SKIP : ST_DATA;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (cnt_q == `OTW_LAST_TX_BIT) begin
                            state_d = ST_RD_ACK;
                            drive_d = 1'b0;
                        end else begin
                            shreg_d = {shreg_q[6:0], 1'b0};
                            drive_d = !shreg_q[6];
                            cnt_d   = cnt_inc(cnt_q);
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        if (sda_hi) begin
                            state_d = ST_SKIP;
                        end else begin
                            cnt_d = `OTW_BITS_PER_BYTE;
                        end
                    end else if (byte_done) begin
                        // Master asked for more: resend a fresh snapshot
                        state_d = ST_RD;
                        cnt_d   = 4'h0;
                        shreg_d = rd_byte;
                        drive_d = !rd_byte[7];
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    state_d = state_q;
                end
                default: begin
                    state_d = ST_IDLE;
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            shreg_q <= 8'h00;
            drive_q <= 1'b0;
            rw_q    <= 1'b0;
            prog_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            shreg_q <= shreg_d;
            drive_q <= drive_d;
            rw_q    <= rw_d;
            prog_q  <= prog_d;
        end
    end

    // ---------------------------------------------------------------
    // Wiper, boot load and fuse request
    // ---------------------------------------------------------------
    // Fuse latches are sampled one edge after reset release, never
    // inside the reset branch itself.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            wiper_q     <= `OTW_MIDSCALE;
            boot_done_q <= 1'b0;
            blow_q      <= 1'b0;
            blown_q     <= 1'b0;
            blow_code_q <= 6'h00;
        end else begin
            boot_done_q <= 1'b1;
            blow_q      <= start_blow;
            if (booting && chk == `OTW_CHK_DONE) begin
                wiper_q <= fuse_code_in;
            end else if (upd_wiper) begin
                wiper_q <= rx_code;
            end
            if (start_blow) begin
                blown_q     <= 1'b1;
                blow_code_q <= rx_code;
            end
        end
    end

    // Open drain: the pad only ever pulls low
    assign sda_out           = 1'b0;
    assign sda_oe_out        = drive_q;
    assign wiper_setting_out = wiper_q;
    assign fuse_blow_out     = blow_q;
    assign fuse_code_out     = blow_code_q;
    assign addressed_out     = (state_q != ST_IDLE) && (state_q != ST_SKIP) && (state_q != ST_ADDR);

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    logic frame_ev;
    assign frame_ev = start_ev || stop_ev;

    sequence byte_end_s(otw_state_t st);
        state_q == st && byte_done;
    endsequence

    sequence ack_end_s(otw_state_t st);
        state_q == st && scl_fall;
    endsequence

    start_enter_a: assert property (start_ev |=> state_q == ST_ADDR && cnt_q == 4'h0)
        else $error("start not taken");
    addr_ack_a: assert property (byte_end_s(ST_ADDR) ##0 addr_ok |=> state_q == ST_ADDR_ACK && sda_oe_out)
        else $error("address not acknowledged");
    addr_miss_a: assert property (byte_end_s(ST_ADDR) ##0 !addr_ok |=> state_q == ST_SKIP && !sda_oe_out)
        else $error("foreign address accepted");
    skip_quiet_a: assert property (state_q == ST_SKIP |-> !sda_oe_out)
        else $error("line driven while not addressed");
    instr_next_a: assert property (ack_end_s(ST_ADDR_ACK) ##0 !rw_q |=> state_q == ST_INSTR && !sda_oe_out)
        else $error("instruction phase missed");
    read_next_a: assert property (ack_end_s(ST_ADDR_ACK) ##0 rw_q |=> state_q == ST_RD
        && shreg_q == $past(rd_byte))
        else $error("read byte not loaded");
    wiper_load_a: assert property (byte_end_s(ST_DATA) ##0 !locked && !booting |=> wiper_q == $past(rx_code))
        else $error("wiper not updated");
    lock_hold_a: assert property (locked && !booting |=> $stable(wiper_q))
        else $error("locked wiper changed");
    blow_fire_a: assert property (start_blow |=> fuse_blow_out && fuse_code_out == wiper_q
        ##1 !fuse_blow_out [*8])
        else $error("fuse request wrong");
    sda_hold_a: assert property (scl_hi && $past(scl_hi) && !$past(frame_ev) |-> $stable(sda_oe_out))
        else $error("line moved while clock high");
    stop_idle_a: assert property (stop_ev |=> state_q == ST_IDLE && !sda_oe_out)
        else $error("stop not honoured");
    boot_mid_a: assert property (booting && chk != `OTW_CHK_DONE |=> wiper_q == `OTW_MIDSCALE)
        else $error("wiper not midscale at boot");

endmodule : otw_slave

`default_nettype wire

// File: bench/otw_bus_master.sv
// Behavioural two-wire bus master that drives the wiper serial slave
`timescale 1ns/1ps
`default_nettype none

module otw_bus_master (
    input  wire logic clk_in,
    input  wire logic sda_in,       // Resolved data line level
    output logic      scl_out,      // Clock line, idles high outside frames
    output logic      sda_low_out   // High while the master pulls data low
);
    // Half period of the bus clock in system cycles; the bench may slow it down
    int half = 8;

    // ---------------------------------------------------------------
    // Pacing and single clock pulses
    // ---------------------------------------------------------------
    // Every change lands a fixed delay after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #10;
    endtask : tick

    // Data moves one cycle into the low phase so it never races the falling edge
    task automatic clk_bit(input logic b, output logic s);
        tick(1);
        sda_low_out = ~b;
        tick(half - 1);
        scl_out = 1'b1;
        tick(half / 2);
        s = sda_in;
        tick(half - half / 2);
        scl_out = 1'b0;
    endtask : clk_bit

    // ---------------------------------------------------------------
    // Frame conditions
    // ---------------------------------------------------------------
    task automatic start_cond();
        sda_low_out = 1'b0;
        scl_out = 1'b1;
        tick(half);
        sda_low_out = 1'b1;
        tick(half);
        scl_out = 1'b0;
    endtask : start_cond

    // Pull data low first so the rise while clock is high forms the stop
    task automatic stop_cond();
        tick(1);
        sda_low_out = 1'b1;
        tick(half - 1);
        scl_out = 1'b1;
        tick(half);
        sda_low_out = 1'b0;
        tick(half);
    endtask : stop_cond

    // ---------------------------------------------------------------
    // Bytes
    // ---------------------------------------------------------------
    // Eight bits MSB first, then the line is released for the slave's answer
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask : wr_byte

    // Line released for eight bits; the ninth carries the master's answer
    task automatic rd_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(~ack_it, s);
    endtask : rd_byte

    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
endmodule : otw_bus_master

`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench for the wiper serial slave
`timescale 1ns/1ps
`default_nettype none
`include "otw_params.svh"

`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end

module tb;
    logic       clk_in, nrst_in, scl, sda_low, sda_wire, sel_pin, chk_hi, chk_lo;
    logic       sda_o, sda_oe, blow, addressed, oe_seen;
    logic [5:0] fcode, fcode_o, wiper;
    int         error_cnt = 0, n_checks = 0, blow_cnt = 0, cyc = 0;

    // Open-drain data line with pull-up: low if either party pulls
    assign sda_wire = ~(sda_low | (sda_oe & ~sda_o));

    otw_bus_master i_mst (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(sda_low));

    otw_slave i_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .addr_select_pin_in(sel_pin), .fuse_check_hi_in(chk_hi),
        .fuse_check_lo_in(chk_lo), .fuse_code_in(fcode), .wiper_setting_out(wiper),
        .fuse_blow_out(blow), .fuse_code_out(fcode_o), .addressed_out(addressed));

    // ---------------------------------------------------------------
    // Clock, fuse macro, watchers
    // ---------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // Fuse latches report success and hold the blown code
    always @(posedge clk_in) begin
        if (blow === 1'b1) begin
            blow_cnt++;
            #10;
            chk_hi = 1'b1;
            chk_lo = 1'b1;
            fcode = fcode_o;
        end
    end

    // Records any slave drive of the data line; also cuts a hang short
    always @(posedge clk_in) begin
        cyc++;
        if (sda_oe === 1'b1) oe_seen = 1'b1;
        if (cyc == 60000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ---------------------------------------------------------------
    // Transaction helpers
    // ---------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #10;
    endtask : tick

    // acks = {address, instruction, first data, second data}
    task automatic wr_xfer(input logic sel, input logic [7:0] ins, input logic [7:0] d0,
                           input logic [7:0] d1, input logic two, output logic [3:0] acks);
        acks = 4'h0;
        i_mst.start_cond();
        i_mst.wr_byte({`OTW_ADDR_PREFIX, sel, 1'b0}, acks[3]);
        i_mst.wr_byte(ins, acks[2]);
        i_mst.wr_byte(d0, acks[1]);
        if (two) i_mst.wr_byte(d1, acks[0]);
        i_mst.stop_cond();
    endtask : wr_xfer

    task automatic rd_xfer(input logic sel, output logic a, output logic [7:0] d);
        i_mst.start_cond();
        i_mst.wr_byte({`OTW_ADDR_PREFIX, sel, 1'b1}, a);
        i_mst.rd_byte(1'b0, d);
        i_mst.stop_cond();
    endtask : rd_xfer

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Midscale at start, repeated reads return status and code
    task automatic t_power_on();
        logic a;
        logic [7:0] d;
        `CHK(wiper, 6'h20);
        for (int k = 0; k < 2; k++) begin
            rd_xfer(1'b0, a, d);
            `CHK(a, 1'b1);
            `CHK(d, {`OTW_CHK_READY, `OTW_MIDSCALE});
        end
        // Master acknowledges the first byte, so a second snapshot follows
        i_mst.start_cond();
        i_mst.wr_byte({`OTW_ADDR_PREFIX, 1'b0, 1'b1}, a);
        i_mst.rd_byte(1'b1, d);
        `CHK(addressed, 1'b1);
        `CHK(d, {`OTW_CHK_READY, `OTW_MIDSCALE});
        i_mst.rd_byte(1'b0, d);
        `CHK(d, {`OTW_CHK_READY, `OTW_MIDSCALE});
        i_mst.stop_cond();
        `CHK(sda_o, 1'b0);
    endtask : t_power_on

    // Upper data bits ignored; further bytes reload; slow master too
    task automatic t_write();
        logic [3:0] acks;
        wr_xfer(1'b0, 8'h00, 8'hE5, 8'h00, 1'b0, acks);
        `CHK(acks, 4'hE);
        `CHK(wiper, 6'h25);
        wr_xfer(1'b0, 8'h00, 8'h11, 8'h4A, 1'b1, acks);
        `CHK(acks, 4'hF);
        `CHK(wiper, 6'h0A);
        i_mst.half = 13;
        wr_xfer(1'b0, 8'h00, 8'h2B, 8'h00, 1'b0, acks);
        i_mst.half = 8;
        `CHK(wiper, 6'h2B);
    endtask : t_write

    // Every pin level against every select bit
    task automatic t_addr();
        logic a;
        logic [7:0] d;
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 2; s++) begin
                sel_pin = p[0];
                tick(4);
                oe_seen = 1'b0;
                rd_xfer(s[0], a, d);
                `CHK(a, logic'(p == s));
                `CHK(oe_seen, logic'(p == s));
            end
        end
        sel_pin = 1'b0;
        tick(4);
    endtask : t_addr

    // Stop in the middle of a data byte leaves the wiper alone
    task automatic t_abort();
        logic a, s;
        i_mst.start_cond();
        i_mst.wr_byte({`OTW_ADDR_PREFIX, 1'b0, 1'b0}, a);
        i_mst.wr_byte(8'h00, a);
        `CHK(a, 1'b1);
        `CHK(addressed, 1'b1);
        for (int i = 0; i < 4; i++) i_mst.clk_bit(1'b0, s);
        i_mst.stop_cond();
        `CHK(wiper, 6'h2B);
        `CHK(addressed, 1'b0);
    endtask : t_abort

    // Failed-fuse codes read back and lock the wiper
    task automatic t_status();
        logic a;
        logic [3:0] acks;
        logic [7:0] d;
        for (int c = 1; c < 3; c++) begin
            {chk_hi, chk_lo} = c[1:0];
            rd_xfer(1'b0, a, d);
            `CHK(d, {c[1:0], 6'h2B});
            wr_xfer(1'b0, 8'h00, 8'h07, 8'h00, 1'b0, acks);
            `CHK(wiper, 6'h2B);
        end
        {chk_hi, chk_lo} = 2'b00;
    endtask : t_status

    // Program, then confirm lock, read-back and reload after reset
    task automatic t_program();
        logic a;
        logic [3:0] acks;
        logic [7:0] d;
        wr_xfer(1'b0, 8'h80, 8'hD5, 8'h11, 1'b1, acks);
        `CHK(blow_cnt, 1);
        `CHK(fcode_o, 6'h15);
        `CHK(acks, 4'hE);
        rd_xfer(1'b0, a, d);
        `CHK(d, {`OTW_CHK_DONE, 6'h15});
        wr_xfer(1'b0, 8'h00, 8'h3F, 8'h00, 1'b0, acks);
        `CHK(wiper, 6'h15);
        nrst_in = 1'b0;
        tick(3);
        nrst_in = 1'b1;
        tick(2);
        `CHK(wiper, 6'h15);
    endtask : t_program

    initial begin
        nrst_in = 1'b0;
        sel_pin = 1'b0;
        chk_hi = 1'b0;
        chk_lo = 1'b0;
        fcode = 6'h00;
        oe_seen = 1'b0;
        tick(3);
        nrst_in = 1'b1;
        tick(4);
        t_power_on();
        t_write();
        t_addr();
        t_abort();
        t_status();
        t_program();
        print_verdict();
    end
endmodule : tb

`default_nettype wire
